// [shared/fmd_map.svh]
// Purpose: Offsets, field positions, codes and reset values of the decoder
// Assumes: Included by bare name; definitions only
// Notes: Byte offsets on the register bus are word aligned
`ifndef FMD_MAP_SVH
`define FMD_MAP_SVH

// Register byte offsets
`define FMD_REG_INSTR 8'h00
`define FMD_REG_PTR 8'h04
`define FMD_REG_STATUS 8'h08
`define FMD_REG_PC 8'h0C
`define FMD_REG_ARIX 8'h10
`define FMD_REG_XFER 8'h14
`define FMD_REG_MADDR 8'h18
`define FMD_REG_MDATA 8'h1C
`define FMD_REG_INTERRUPT_CONTEXT_REG 8'h20
`define FMD_REG_STACK 8'h24

// Field positions inside registers
`define FMD_PTR_ENABLE_BIT 4
`define FMD_PTR_BANK_BIT 5
`define FMD_INTERRUPT_CONTEXT_REG_ACCEPT_BIT 8

// Operation codes, bits 15 to 11 of the word
`define FMD_OP_ADD_RM 5'h00
`define FMD_OP_SUB_RM 5'h01
`define FMD_OP_ADD_WITH_CARRY_RM 5'h02
`define FMD_OP_SUBTRACT_WITH_BORROW_RM 5'h03
`define FMD_OP_AND_RM 5'h04
`define FMD_OP_XOR_RM 5'h05
`define FMD_OP_OR_RM 5'h06
`define FMD_OP_SPECIAL 5'h07
`define FMD_OP_LOAD 5'h08
`define FMD_OP_MOV_IND_W 5'h0A
`define FMD_OP_STORE 5'h18
`define FMD_OP_MOV_IND_R 5'h1A
`define FMD_OP_CALL 5'h1C
`define FMD_OP_MOV_IMM 5'h1D

// Sub codes in the column field of the special group
`define FMD_SUB_INC_AR 4'h9
`define FMD_SUB_INC_IX 4'h8
`define FMD_SUB_PUSH_AR 4'hD
`define FMD_SUB_POP_AR 4'hC
`define FMD_SUB_GET 4'hB
`define FMD_SUB_PUT 4'hA
`define FMD_SUB_PEEK 4'h3
`define FMD_SUB_POKE 4'h2
`define FMD_SUB_BR_AR 4'h4
`define FMD_SUB_SYSCALL 4'h5

// Last transfer kind, one hot
`define FMD_XFER_GET 4'h1
`define FMD_XFER_PUT 4'h2
`define FMD_XFER_PEEK 4'h4
`define FMD_XFER_POKE 4'h8

// Reset values
`define FMD_RST_PC 14'h0000
`define FMD_RST_SP 3'h0
`define FMD_RST_WORD 16'h0000

`endif

// [shared/fmd_pkg.sv]
// Purpose: Types shared by the decoder modules
// Assumes: Used by scoped names only
// Notes: Constants live in fmd_map.svh
package fmd_pkg;

	// Fields carried out of one instruction word
	typedef struct packed {
		logic [4:0] op;
		logic [2:0] row_field;
		logic [3:0] column_field;
		logic [3:0] immediate_nibble;
		logic [10:0] target;
		logic [1:0] page;
		logic [2:0] entry_hi;
		logic [3:0] entry_lo;
		logic [6:0] periph_addr;
		logic [6:0] rfile_addr;
	} fmd_fields_type;

	// Datapath operation, equal to the low three operation code bits
	typedef enum logic [2:0] {
		FMD_ALU_ADD = 3'h0,
		FMD_ALU_SUB = 3'h1,
		FMD_ALU_ADD_WITH_CARRY = 3'h2,
		FMD_ALU_SUBTRACT_WITH_BORROW = 3'h3,
		FMD_ALU_AND = 3'h4,
		FMD_ALU_XOR = 3'h5,
		FMD_ALU_OR = 3'h6,
		FMD_ALU_PASS = 3'h7
	} fmd_alu_op_type;

	// Bus answer sequence
	typedef enum logic [1:0] {
		FMD_BUS_IDLE = 2'h1,
		FMD_BUS_DONE = 2'h2
	} fmd_bus_state_type;

endpackage

// [hdl/fmd_field_split.sv]
// Purpose: Split one instruction word into its operand fields
// Assumes: Pure combinational; word is stable while read
// Notes: Fields overlap; the caller picks by operation code
`timescale 1ns/10ps
module fmd_field_split (
	input wire logic [15:0] word,
	output fmd_pkg::fmd_fields_type fields
);

	// Field extraction
	always_comb begin
		fields.op = word[15:11];
		fields.row_field = word[10:8];
		fields.column_field = word[7:4];
		fields.immediate_nibble = word[3:0];
		fields.target = word[10:0];
		fields.page = word[12:11];
		fields.entry_hi = word[10:8];
		fields.entry_lo = word[3:0];
		fields.periph_addr = {word[10:8], word[3:0]};
		fields.rfile_addr = {word[10:8], word[3:0]};
	end

endmodule

// [hdl/fmd_alu.sv]
// Purpose: Nibble datapath with carry and borrow
// Assumes: Carry in is used only by the with-carry and with-borrow operations
// Notes: Carry out doubles as borrow for subtraction
`timescale 1ns/10ps
module fmd_alu (
	input wire logic [3:0] a,
	input wire logic [3:0] b,
	input wire logic cin,
	input wire fmd_pkg::fmd_alu_op_type op,
	output logic [3:0] y,
	output logic cout
);

	// Five bit result keeps the carry or borrow
	always_comb begin
		logic [4:0] s;
		s = 5'h00;
		case (op)
			fmd_pkg::FMD_ALU_ADD: s = {1'b0, a} + {1'b0, b};
			fmd_pkg::FMD_ALU_ADD_WITH_CARRY: s = {1'b0, a} + {1'b0, b} + {4'h0, cin};
			fmd_pkg::FMD_ALU_SUB: s = {1'b0, a} - {1'b0, b};
			fmd_pkg::FMD_ALU_SUBTRACT_WITH_BORROW: s = {1'b0, a} - {1'b0, b} - {4'h0, cin};
			fmd_pkg::FMD_ALU_AND: s = {1'b0, a & b};
			fmd_pkg::FMD_ALU_OR: s = {1'b0, a | b};
			fmd_pkg::FMD_ALU_XOR: s = {1'b0, a ^ b};
			default: s = {1'b0, b};
		endcase
		y = s[3:0];
		cout = s[4];
	end

endmodule

// [hdl/fmd_decoder.sv]
// Purpose: Instruction decoder and nibble datapath of a 4-bit core
// Assumes: Words arrive by writes to the instruction register
// Notes: One word executes per accepted write; skips are not modelled
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`include "fmd_map.svh"
module fmd_decoder #(
	parameter int STACK_DEPTH = 8,
	parameter int ISTACK_DEPTH = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	localparam int SPW = $clog2(STACK_DEPTH);
	localparam int ISPW = $clog2(ISTACK_DEPTH);

	// Merge write data into an old value by byte lane
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Storage arrays
	logic [3:0] dmem [256];
	logic [15:0] astack [STACK_DEPTH];
	logic [3:0] istack [ISTACK_DEPTH];

	// Architectural state
	fmd_pkg::fmd_bus_state_type bus_state, next_bus_state;
	logic [31:0] next_readdata;
	logic next_waitrequest;
	logic [13:0] pc, next_pc;
	logic carry_flag, next_carry_flag;
	logic [15:0] address_register, next_address_register;
	logic [15:0] index_register, next_index_register;
	logic [SPW-1:0] stack_pointer, next_stack_pointer;
	logic [ISPW-1:0] istack_pointer, next_istack_pointer;
	logic [3:0] row_pointer, next_row_pointer;
	logic row_pointer_enable, next_row_pointer_enable;
	logic bank, next_bank;
	logic [3:0] interrupt_context_reg, next_interrupt_context_reg;
	logic [15:0] last_word, next_last_word;
	logic [3:0] xfer_kind, next_xfer_kind;
	logic [6:0] periph_addr, next_periph_addr;
	logic [6:0] rfile_addr, next_rfile_addr;
	logic [7:0] mem_addr, next_mem_addr;

	// Array write requests
	logic dm_we;
	logic [7:0] dm_wa;
	logic [3:0] dm_wd;
	logic as_we;
	logic [SPW-1:0] as_wa;
	logic [15:0] as_wd;
	logic is_we;
	logic [ISPW-1:0] is_wa;

	// Decode of the word being written
	logic [31:0] rd_value;
	logic [31:0] merged;
	logic accept;
	logic [15:0] word;
	fmd_pkg::fmd_fields_type f;
	logic [7:0] m_addr, gr_addr, ind_addr;
	logic [3:0] m_val, gr_val, ind_val;
	logic [3:0] alu_a, alu_b, alu_y;
	logic alu_c;
	logic [15:0] stack_entry;

	assign accept = (avs_read | avs_write) & (bus_state == fmd_pkg::FMD_BUS_DONE);
	assign merged = be_merge(rd_value, avs_writedata, avs_byteenable);
	assign word = merged[15:0];

	fmd_field_split u_split (
		.word(word),
		.fields(f)
	);

	assign m_addr = {bank, f.row_field, f.column_field};
	// General registers sit in row 0 of the current bank
	assign gr_addr = {bank, 3'h0, f.immediate_nibble};
	assign m_val = dmem[m_addr];
	assign gr_val = dmem[gr_addr];
	assign ind_addr = row_pointer_enable ? {row_pointer, gr_val} : {bank, f.row_field, gr_val};
	assign ind_val = dmem[ind_addr];
	assign stack_entry = astack[stack_pointer];

	// Register form works on the register, immediate form on memory
	assign alu_a = f.op[4] ? m_val : gr_val;
	assign alu_b = f.op[4] ? f.immediate_nibble : m_val;

	fmd_alu u_alu (
		.a(alu_a),
		.b(alu_b),
		.cin(carry_flag),
		.op(fmd_pkg::fmd_alu_op_type'(f.op[2:0])),
		.y(alu_y),
		.cout(alu_c)
	);

	// Read view of every register
	always_comb begin
		rd_value = 32'h00000000;
		case (avs_address)
			`FMD_REG_INSTR: rd_value = {16'h0000, last_word};
			`FMD_REG_PTR: rd_value = {26'h0, bank, row_pointer_enable, row_pointer};
			`FMD_REG_STATUS: rd_value = {22'h0, 2'(istack_pointer), 1'b0, 3'(stack_pointer), 3'h0, carry_flag};
			`FMD_REG_PC: rd_value = {18'h0, pc};
			`FMD_REG_ARIX: rd_value = {index_register, address_register};
			`FMD_REG_XFER: rd_value = {12'h0, xfer_kind, 1'b0, rfile_addr, 1'b0, periph_addr};
			`FMD_REG_MADDR: rd_value = {24'h0, mem_addr};
			`FMD_REG_MDATA: rd_value = {28'h0, dmem[mem_addr]};
			// Saved context at the stack top sits beside the live one; undefined until a push
			`FMD_REG_INTERRUPT_CONTEXT_REG: rd_value = {24'h000000, istack[istack_pointer], interrupt_context_reg};
			`FMD_REG_STACK: rd_value = {16'h0, stack_entry};
			default: rd_value = 32'h00000000;
		endcase
	end

	// Bus answer: one wait cycle, then the request is accepted
	always_comb begin
		next_bus_state = bus_state;
		next_waitrequest = 1'b1;
		next_readdata = avs_readdata;
		case (bus_state)
			fmd_pkg::FMD_BUS_IDLE: begin
				if (avs_read | avs_write) begin
					next_bus_state = fmd_pkg::FMD_BUS_DONE;
					next_waitrequest = 1'b0;
					next_readdata = avs_read ? rd_value : 32'h00000000;
				end
			end
			fmd_pkg::FMD_BUS_DONE: next_bus_state = fmd_pkg::FMD_BUS_IDLE;
			default: next_bus_state = fmd_pkg::FMD_BUS_IDLE;
		endcase
	end

	// Next state of registers and arrays
	always_comb begin
		next_pc = pc;
		next_carry_flag = carry_flag;
		next_address_register = address_register;
		next_index_register = index_register;
		next_stack_pointer = stack_pointer;
		next_istack_pointer = istack_pointer;
		next_row_pointer = row_pointer;
		next_row_pointer_enable = row_pointer_enable;
		next_bank = bank;
		next_interrupt_context_reg = interrupt_context_reg;
		next_last_word = last_word;
		next_xfer_kind = xfer_kind;
		next_periph_addr = periph_addr;
		next_rfile_addr = rfile_addr;
		next_mem_addr = mem_addr;
		dm_we = 1'b0;
		dm_wa = m_addr;
		dm_wd = alu_y;
		as_we = 1'b0;
		as_wa = stack_pointer - 1'b1;
		as_wd = address_register;
		is_we = 1'b0;
		is_wa = istack_pointer - 1'b1;
		if (accept && avs_write) begin
			case (avs_address)
				`FMD_REG_PTR: begin
					next_row_pointer = merged[3:0];
					next_row_pointer_enable = merged[`FMD_PTR_ENABLE_BIT];
					next_bank = merged[`FMD_PTR_BANK_BIT];
				end
				`FMD_REG_PC: next_pc = merged[13:0];
				`FMD_REG_ARIX: begin
					next_address_register = merged[15:0];
					next_index_register = merged[31:16];
				end
				`FMD_REG_MADDR: next_mem_addr = merged[7:0];
				`FMD_REG_MDATA: begin
					dm_we = 1'b1;
					dm_wa = mem_addr;
					dm_wd = merged[3:0];
				end
				`FMD_REG_INTERRUPT_CONTEXT_REG: begin
					next_interrupt_context_reg = merged[3:0];
					if (merged[`FMD_INTERRUPT_CONTEXT_REG_ACCEPT_BIT]) begin
						is_we = 1'b1;
						next_istack_pointer = is_wa;
					end
				end
				`FMD_REG_INSTR: begin
					next_last_word = word;
					next_pc = pc + 14'h0001;
					if (!f.op[4] && f.op[3:2] == 2'h3) begin
						next_pc = {pc[13], f.page, f.target};
					end else if (f.op == `FMD_OP_CALL) begin
						as_we = 1'b1;
						as_wd = {2'h0, pc + 14'h0001};
						next_stack_pointer = as_wa;
						next_pc = {pc[13:12], 1'b0, f.target};
					end else if (f.op == `FMD_OP_SPECIAL) begin
						case (f.column_field)
							`FMD_SUB_INC_AR: begin
								if (f.row_field == 3'h0 && f.immediate_nibble == 4'h0) begin
									next_address_register = address_register + 16'h0001;
								end
							end
							`FMD_SUB_INC_IX: begin
								if (f.row_field == 3'h0 && f.immediate_nibble == 4'h0) begin
									next_index_register = index_register + 16'h0001;
								end
							end
							`FMD_SUB_PUSH_AR: begin
								as_we = 1'b1;
								next_stack_pointer = as_wa;
							end
							`FMD_SUB_POP_AR: begin
								next_address_register = stack_entry;
								next_stack_pointer = stack_pointer + 1'b1;
							end
							`FMD_SUB_BR_AR: next_pc = address_register[13:0];
							`FMD_SUB_SYSCALL: next_pc = {pc[13], 2'h0, f.entry_hi, 4'h0, f.entry_lo};
							`FMD_SUB_GET, `FMD_SUB_PUT: begin
								next_periph_addr = f.periph_addr;
								next_xfer_kind = f.column_field[0] ? `FMD_XFER_GET : `FMD_XFER_PUT;
							end
							`FMD_SUB_PEEK, `FMD_SUB_POKE: begin
								next_rfile_addr = f.rfile_addr;
								next_xfer_kind = f.column_field[0] ? `FMD_XFER_PEEK : `FMD_XFER_POKE;
							end
							default: next_xfer_kind = xfer_kind;
						endcase
					end else if (f.op[3] == 1'b0) begin
						dm_we = 1'b1;
						dm_wa = f.op[4] ? m_addr : gr_addr;
						if (f.op[2] == 1'b0) begin
							next_carry_flag = alu_c;
						end
					end else begin
						case (f.op)
							`FMD_OP_LOAD: begin
								dm_we = 1'b1;
								dm_wa = gr_addr;
								dm_wd = m_val;
							end
							`FMD_OP_STORE: begin
								dm_we = 1'b1;
								dm_wd = gr_val;
							end
							`FMD_OP_MOV_IND_W: begin
								dm_we = 1'b1;
								dm_wa = ind_addr;
								dm_wd = m_val;
							end
							`FMD_OP_MOV_IND_R: begin
								dm_we = 1'b1;
								dm_wd = ind_val;
							end
							`FMD_OP_MOV_IMM: begin
								dm_we = 1'b1;
								dm_wd = f.immediate_nibble;
							end
							default: dm_we = 1'b0;
						endcase
					end
				end
				default: dm_we = 1'b0;
			endcase
		end
	end

	// Register stage for the bus and the core state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_state <= fmd_pkg::FMD_BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
			pc <= `FMD_RST_PC;
			carry_flag <= 1'b0;
			address_register <= `FMD_RST_WORD;
			index_register <= `FMD_RST_WORD;
			stack_pointer <= '0;
			istack_pointer <= '0;
			row_pointer <= 4'h0;
			row_pointer_enable <= 1'b0;
			bank <= 1'b0;
			interrupt_context_reg <= 4'h0;
			last_word <= `FMD_RST_WORD;
			xfer_kind <= 4'h0;
			periph_addr <= 7'h00;
			rfile_addr <= 7'h00;
			mem_addr <= 8'h00;
		end else begin
			bus_state <= next_bus_state;
			avs_waitrequest <= next_waitrequest;
			avs_readdata <= next_readdata;
			pc <= next_pc;
			carry_flag <= next_carry_flag;
			address_register <= next_address_register;
			index_register <= next_index_register;
			stack_pointer <= next_stack_pointer;
			istack_pointer <= next_istack_pointer;
			row_pointer <= next_row_pointer;
			row_pointer_enable <= next_row_pointer_enable;
			bank <= next_bank;
			interrupt_context_reg <= next_interrupt_context_reg;
			last_word <= next_last_word;
			xfer_kind <= next_xfer_kind;
			periph_addr <= next_periph_addr;
			rfile_addr <= next_rfile_addr;
			mem_addr <= next_mem_addr;
		end
	end

	// Arrays hold no reset; contents are undefined after power up
	always_ff @(posedge sys_clk) begin
		if (dm_we) begin
			dmem[dm_wa] <= dm_wd;
		end
		if (as_we) begin
			astack[as_wa] <= as_wd;
		end
		if (is_we) begin
			istack[is_wa] <= interrupt_context_reg;
		end
	end

endmodule

// [dv/fmd_decoder_checker.sv]
// Purpose: Bus timing and pointer read-back checks on the decoder ports
// Assumes: Single master; request held until waitrequest samples low
// Notes: Pointer shadow follows byte lane 0 only, enough for bits 5 to 0
`timescale 1ns/10ps
`include "fmd_map.svh"
module fmd_decoder_checker #(
	parameter int STACK_DEPTH = 8,
	parameter int ISTACK_DEPTH = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	logic [5:0] ptr_shadow;
	logic [5:0] next_ptr_shadow;
	// Track what software last put into the pointer register
	always_comb begin
		next_ptr_shadow = ptr_shadow;
		if (avs_write && !avs_waitrequest && avs_address == `FMD_REG_PTR && avs_byteenable[0]) begin
			next_ptr_shadow = avs_writedata[5:0];
		end
	end
	// Register the shadow; reset value matches the design
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_shadow <= 6'h00;
		end else begin
			ptr_shadow <= next_ptr_shadow;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	chk_wait_drop: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("Waitrequest did not drop one cycle after a request");
	chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("Waitrequest stayed low for more than one cycle");
	chk_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("Waitrequest dropped without a request");
	chk_write_zero: assert property (!avs_waitrequest && avs_write |-> avs_readdata == 32'h00000000)
		else $error("Read data not cleared on a write answer");
	chk_unmapped_zero: assert property (!avs_waitrequest && avs_read && avs_address > `FMD_REG_STACK
		|-> avs_readdata == 32'h00000000) else $error("Unmapped read returned nonzero data");
	chk_data_hold: assert property (!$stable(avs_readdata) |-> !avs_waitrequest)
		else $error("Read data changed outside an answer");
	chk_ptr_readback: assert property (!avs_waitrequest && avs_read && avs_address == `FMD_REG_PTR
		|-> avs_readdata[5:0] == ptr_shadow) else $error("Pointer register read back wrong");
	chk_reset_idle: assert property ($rose(rst_n) |-> avs_waitrequest && avs_readdata == 32'h00000000)
		else $error("Bus not idle after reset release");
	cover property (avs_write && !avs_waitrequest && avs_address == `FMD_REG_INSTR);
	cover property (avs_read && !avs_waitrequest && avs_address == `FMD_REG_STACK);
	cover property (avs_read && !avs_waitrequest && avs_address == `FMD_REG_XFER);
endmodule
bind fmd_decoder fmd_decoder_checker #(.STACK_DEPTH(STACK_DEPTH), .ISTACK_DEPTH(ISTACK_DEPTH)) chk_u (
	.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest));

// [dv/fmd_prog_mem.sv]
// Purpose: Program memory holding the fixed instruction words of the bench
// Assumes: Read combinationally; address settles one cycle before use
// Notes: Unused places return all ones, a word the decoder treats as no-op
`timescale 1ns/10ps
module fmd_prog_mem (
	input wire logic [2:0] rom_addr,
	output logic [15:0] rom_word
);
	// Fixed program table
	always_comb begin
		case (rom_addr)
			3'h0: rom_word = 16'h3890; // Bump address register
			3'h1: rom_word = 16'h3880; // Bump index register
			3'h2: rom_word = 16'h3990; // Bump with nonzero row, must be ignored
			3'h3: rom_word = 16'hE123; // Call
			3'h4: rom_word = 16'h3D5A; // System call
			3'h5: rom_word = 16'h5142; // Indirect move
			default: rom_word = 16'hFFFF;
		endcase
	end
endmodule

// [dv/fmd_decoder_tb.sv]
// Purpose: Self-checking bench for the instruction decoder
// Assumes: Words reach the decoder by writes to the instruction register
// Notes: Expected values come from field layouts, never from the design
`timescale 1ns/10ps
`include "fmd_map.svh"
module fmd_decoder_tb;
	logic sys_clk, rst_n, avs_read, avs_write;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic avs_waitrequest;
	logic [2:0] rom_addr;
	logic [15:0] rom_word;
	int failures, cmp_count;
	fmd_decoder dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	fmd_prog_mem mem_u (.rom_addr(rom_addr), .rom_word(rom_word));
	// Free running 20 MHz clock
	always #25 sys_clk = ~sys_clk;
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	// One bus cycle; request held until waitrequest is sampled low
	task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		// No cycle count assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus_xfer(1'b1, a, d, 4'hF, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string msg);
		logic [31:0] q;
		bus_xfer(1'b0, a, 32'h0, 4'hF, q);
		chk(q & mask, exp, msg);
	endtask
	task automatic exec_rom(input logic [2:0] k);
		rom_addr <= k;
		@(posedge sys_clk);
		wr(`FMD_REG_INSTR, {16'h0, rom_word});
	endtask
	task automatic t_reset();
		rd_chk(`FMD_REG_PC, 32'hFFFFFFFF, 32'h0, "pc reset");
		rd_chk(`FMD_REG_STATUS, 32'hFFFFFFFF, 32'h0, "status reset");
		wr(8'h40, 32'hFFFFFFFF);
		rd_chk(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped read");
	endtask
	task automatic t_alu();
		logic [4:0] ops [10] = '{5'h00, 5'h02, 5'h12, 5'h01, 5'h03, 5'h13, 5'h04, 5'h05, 5'h06, 5'h16};
		logic [3:0] a, b;
		logic [4:0] s;
		logic cy, md;
		cy = 1'b0;
		for (int i = 0; i < 10; i++) begin
			wr(`FMD_REG_MADDR, 32'h01);
			wr(`FMD_REG_MDATA, 32'hC);
			wr(`FMD_REG_MADDR, 32'h35);
			wr(`FMD_REG_MDATA, 32'h7);
			md = ops[i][4];
			a = md ? 4'h7 : 4'hC;
			b = md ? 4'h9 : 4'h7;
			case (ops[i][2:0])
				3'h0: s = {1'b0, a} + {1'b0, b};
				3'h2: s = {1'b0, a} + {1'b0, b} + {4'h0, cy};
				3'h1: s = {1'b0, a} - {1'b0, b};
				3'h3: s = {1'b0, a} - {1'b0, b} - {4'h0, cy};
				3'h4: s = {cy, a & b};
				3'h5: s = {cy, a ^ b};
				default: s = {cy, a | b};
			endcase
			cy = s[4];
			wr(`FMD_REG_INSTR, {16'h0, ops[i], 3'h3, 4'h5, md ? 4'h9 : 4'h1});
			wr(`FMD_REG_MADDR, md ? 32'h35 : 32'h01);
			rd_chk(`FMD_REG_MDATA, 32'hF, {28'h0, s[3:0]}, "alu result");
			rd_chk(`FMD_REG_STATUS, 32'h1, {31'h0, cy}, "carry flag");
		end
	endtask
	task automatic t_special();
		logic [31:0] q;
		wr(`FMD_REG_ARIX, 32'h1234AB00);
		bus_xfer(1'b1, `FMD_REG_ARIX, 32'h555500FF, 4'h1, q);
		for (int k = 0; k < 3; k++) exec_rom(3'(k));
		rd_chk(`FMD_REG_ARIX, 32'hFFFFFFFF, 32'h1235AC00, "address and index bump");
	endtask
	task automatic t_branch();
		wr(`FMD_REG_PC, 32'h2000);
		for (int p = 0; p < 4; p++) begin
			wr(`FMD_REG_INSTR, {16'h0, 3'b011, 2'(p), 11'h2A5});
			rd_chk(`FMD_REG_PC, 32'h3FFF, {18'h0, 1'b1, 2'(p), 11'h2A5}, "branch target");
		end
		exec_rom(3'h3);
		rd_chk(`FMD_REG_PC, 32'h3FFF, 32'h3123, "call target");
		rd_chk(`FMD_REG_STATUS, 32'h70, 32'h70, "stack pointer after call");
		rd_chk(`FMD_REG_STACK, 32'h3FFF, 32'h3AA6, "return address");
		exec_rom(3'h4);
		rd_chk(`FMD_REG_PC, 32'h3FFF, 32'h250A, "system call entry");
	endtask
	task automatic t_xfer();
		logic [3:0] subs [4] = '{4'hB, 4'hA, 4'h3, 4'h2};
		logic [2:0] hi;
		logic [3:0] lo, kind;
		for (int i = 0; i < 4; i++) begin
			hi = 3'(i + 3);
			lo = 4'(12 - i);
			kind = 4'h1 << i;
			wr(`FMD_REG_INSTR, {16'h0, 5'h07, hi, subs[i], lo});
			if (i < 2) rd_chk(`FMD_REG_XFER, 32'h000F007F, {12'h0, kind, 9'h0, hi, lo}, "periph addr");
			else rd_chk(`FMD_REG_XFER, 32'h000F7F00, {12'h0, kind, 1'b0, hi, lo, 8'h0}, "rfile addr");
		end
	endtask
	task automatic t_indirect();
		wr(`FMD_REG_MADDR, 32'h02);
		wr(`FMD_REG_MDATA, 32'h6);
		wr(`FMD_REG_MADDR, 32'h14);
		wr(`FMD_REG_MDATA, 32'hA);
		wr(`FMD_REG_PTR, 32'h15);
		exec_rom(3'h5);
		wr(`FMD_REG_MADDR, 32'h56);
		rd_chk(`FMD_REG_MDATA, 32'hF, 32'hA, "move through pointer");
		wr(`FMD_REG_PTR, 32'h05);
		wr(`FMD_REG_MADDR, 32'h14);
		wr(`FMD_REG_MDATA, 32'h3);
		exec_rom(3'h5);
		wr(`FMD_REG_MADDR, 32'h16);
		rd_chk(`FMD_REG_MDATA, 32'hF, 32'h3, "move through row field");
		rd_chk(`FMD_REG_PTR, 32'h3F, 32'h05, "pointer read back");
	endtask
	// Interrupt context push, address stack push and pop, branch through address
	task automatic t_stack_interrupt_context_reg();
		wr(`FMD_REG_INTERRUPT_CONTEXT_REG, 32'h3);
		wr(`FMD_REG_INTERRUPT_CONTEXT_REG, 32'h105);
		rd_chk(`FMD_REG_STATUS, 32'h300, 32'h300, "interrupt stack pointer");
		rd_chk(`FMD_REG_INTERRUPT_CONTEXT_REG, 32'hFF, 32'h35, "saved context");
		wr(`FMD_REG_ARIX, 32'h0000AC00);
		wr(`FMD_REG_INSTR, 32'h38D0);
		rd_chk(`FMD_REG_STACK, 32'hFFFF, 32'hAC00, "pushed address");
		wr(`FMD_REG_ARIX, 32'h0);
		wr(`FMD_REG_INSTR, 32'h38C0);
		rd_chk(`FMD_REG_ARIX, 32'hFFFF, 32'hAC00, "popped address");
		wr(`FMD_REG_INSTR, 32'h3840);
		rd_chk(`FMD_REG_PC, 32'h3FFF, 32'h2C00, "branch through address");
	endtask
	// Watchdog sized well above the few hundred cycles the tests take
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		wrap_up();
	end
	// Reset, then the scenarios in turn
	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		rom_addr = 3'h0;
		failures = 0;
		cmp_count = 0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_alu();
		t_special();
		t_branch();
		t_xfer();
		t_indirect();
		t_stack_interrupt_context_reg();
		wrap_up();
	end
endmodule
